// ---- common/pwmpm_defs.svh ----
// Offsets, field positions, reset values and pin indices of the PWM pin mux
`ifndef PWMPM_DEFS_SVH
`define PWMPM_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PWMPM_ADDR_ROUTE0     16'h2047
`define PWMPM_ADDR_ROUTE1     16'h2048
`define PWMPM_ADDR_EVENT      16'h2049
`define PWMPM_ADDR_PRELOAD    16'h204A
`define PWMPM_ADDR_ACTIVE     16'h204B
`define PWMPM_ADDR_CTRL_A     16'h204C
`define PWMPM_ADDR_CTRL_B     16'h204D
`define PWMPM_ADDR_SYS_CFG    16'h205E

// ****************************************************************
// Reset values
// ****************************************************************
`define PWMPM_RST_BYTE        8'h00
`define PWMPM_RST_CFG         4'h0
`define PWMPM_RST_CTRL        2'h0

// ****************************************************************
// Field positions
// ****************************************************************
`define PWMPM_R0_ETR_EN       7
`define PWMPM_R0_ETR_SEL      6
`define PWMPM_R0_CH3_HI       5
`define PWMPM_R0_CH3_LO       4
`define PWMPM_R0_CH2_HI       3
`define PWMPM_R0_CH2_LO       2
`define PWMPM_R0_CH1_HI       1
`define PWMPM_R0_CH1_LO       0
`define PWMPM_R1_BRK_EN       7
`define PWMPM_R1_BRK_HI       6
`define PWMPM_R1_BRK_LO       5
`define PWMPM_R1_CH3N_SEL     4
`define PWMPM_R1_CH2N_SEL     3
`define PWMPM_R1_CH1N_SEL     2
`define PWMPM_R1_B_CH2_SEL    1
`define PWMPM_R1_B_CH1_SEL    0
`define PWMPM_CFG_B_EN        3
`define PWMPM_CFG_A_EN        2
`define PWMPM_CFG_B_CLK       1
`define PWMPM_CFG_A_CLK       0
`define PWMPM_EV_A_UG         0
`define PWMPM_EV_A_COMMUTATION_GENERATE_BIT       1
`define PWMPM_EV_B_UG         2
`define PWMPM_CTRL_RUN        0
`define PWMPM_CTRL_DIR        1

// ****************************************************************
// Pin indices
// ****************************************************************
`define PWMPM_NPIN            19
`define PWMPM_NSRC            8
`define PWMPM_PIN_PA1         0
`define PWMPM_PIN_PA3         1
`define PWMPM_PIN_PA4         2
`define PWMPM_PIN_PA5         3
`define PWMPM_PIN_PB0         4
`define PWMPM_PIN_PB1         5
`define PWMPM_PIN_PB2         6
`define PWMPM_PIN_PB5         7
`define PWMPM_PIN_PB6         8
`define PWMPM_PIN_PB7         9
`define PWMPM_PIN_PC2         10
`define PWMPM_PIN_PC4         11
`define PWMPM_PIN_PC6         12
`define PWMPM_PIN_PC7         13
`define PWMPM_PIN_PD0         14
`define PWMPM_PIN_PD1         15
`define PWMPM_PIN_PD2         16
`define PWMPM_PIN_PD3         17
`define PWMPM_PIN_PD4         18

`endif

// ---- common/pwmpm_pkg.sv ----
// Types shared by the PWM pin mux design
`include "pwmpm_defs.svh"

package pwmpm_pkg;

	typedef logic [`PWMPM_NPIN-1:0] pwmpm_pin_vec_t;
	typedef logic [7:0]             pwmpm_byte_t;
	typedef logic [1:0]             pwmpm_sel3_t;

	// Output sources, lowest index wins a shared pin
	typedef enum {
		PWMPM_SRC_A_CH1,
		PWMPM_SRC_A_CH2,
		PWMPM_SRC_A_CH3,
		PWMPM_SRC_A_CH1N,
		PWMPM_SRC_A_CH2N,
		PWMPM_SRC_A_CH3N,
		PWMPM_SRC_B_CH1,
		PWMPM_SRC_B_CH2
	} pwmpm_src_t;

endpackage : pwmpm_pkg

// ---- rtl/pwmpm_sync2.sv ----
// Two-stage crossing for one control bit
`timescale 1ns/1ps

module pwmpm_sync2 (
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// Data
	input  wire logic d_i,
	output logic      q_o
);

	logic stage1_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			stage1_q <= 1'b0;
			q_o      <= 1'b0;
		end else begin
			stage1_q <= d_i;
			q_o      <= stage1_q;
		end
	end

endmodule : pwmpm_sync2

// ---- rtl/pwmpm_top.sv ----
// Pin routing, unit enable and clock source control for two PWM timers
`timescale 1ns/1ps
`include "pwmpm_defs.svh"

// Summary of operation
// - The trigger input reads a pin only while its enable bit is 1, bit 6 picks PA3 or PD4.
// - Timer A channel 3 goes to PD4, PB2 or PC4 for selector codes 0, 1, 2.
// - Timer A channel 2 goes to PB0, PB6 or PC6 for selector codes 0, 1, 2.
// - Timer A channel 1 goes to PB1, PB7 or PC7 for selector codes 0, 1, 2.
// - The break input reads a pin only while enabled, PA1, PB0 or PC6 by a two-bit code.
// - Clearing a unit enable resets that timer's counter and stops its clock.
// - Each clock-source bit picks the 24 MHz PLL clock at 0 and the crystal clock at 1.
// - A commutation event on timer A moves preloaded output settings to active.
// - Run and direction bits cross through two stages and read back late.
module pwmpm_top
	import pwmpm_pkg::*;
(
	// Clock and reset
	input  wire logic                 CLK_SYS_I,
	input  wire logic                 RST_I,
	// Register port
	input  wire logic [15:0]          ADDR_I,
	input  wire logic [7:0]           WDATA_I,
	input  wire logic                 WR_I,
	input  wire logic                 RD_I,
	output logic      [7:0]           RDATA_O,
	// Timer side signals
	input  wire logic [2:0]           TA_CH_OUT_I,
	input  wire logic [2:0]           TA_CHN_OUT_I,
	input  wire logic [2:0]           TA_CH_DIR_I,
	input  wire logic [1:0]           TB_CH_OUT_I,
	input  wire logic [1:0]           TB_CH_DIR_I,
	output logic      [2:0]           TA_CH_IN_O,
	output logic      [1:0]           TB_CH_IN_O,
	output logic                      EXT_TRIG_O,
	output logic                      BREAK_O,
	// Timer unit control
	output logic                      TA_CLK_EN_O,
	output logic                      TA_CNT_RST_O,
	output logic                      TA_CLK_SEL_O,
	output logic                      TA_RUN_O,
	output logic                      TA_DIR_O,
	output logic                      TA_UPDATE_GEN_O,
	output logic                      TA_COMMUT_GEN_O,
	output logic      [7:0]           TA_COMMUT_CFG_O,
	output logic                      TB_CLK_EN_O,
	output logic                      TB_CNT_RST_O,
	output logic                      TB_CLK_SEL_O,
	output logic                      TB_RUN_O,
	output logic                      TB_DIR_O,
	output logic                      TB_UPDATE_GEN_O,
	// Port pins
	input  wire logic [`PWMPM_NPIN-1:0] PIN_IN_I,
	output logic      [`PWMPM_NPIN-1:0] PIN_ALT_EN_O,
	output logic      [`PWMPM_NPIN-1:0] PIN_ALT_OE_O,
	output logic      [`PWMPM_NPIN-1:0] PIN_ALT_OUT_O
);

	// ****************************************************************
	// Selector helpers
	// ****************************************************************
	function automatic pwmpm_pin_vec_t hot3(input pwmpm_sel3_t code,
			input int p0, input int p1, input int p2);
		pwmpm_pin_vec_t v;
		v = '0;
		case (code)
			2'h0: v[p0] = 1'b1;
			2'h1: v[p1] = 1'b1;
			2'h2: v[p2] = 1'b1;
			default: v = '0;
		endcase
		return v;
	endfunction : hot3

	function automatic pwmpm_pin_vec_t hot2(input logic code,
			input int p0, input int p1);
		pwmpm_pin_vec_t v;
		v = '0;
		v[code ? p1 : p0] = 1'b1;
		return v;
	endfunction : hot2

	// ****************************************************************
	// Registers
	// ****************************************************************
	pwmpm_byte_t route0_q;
	pwmpm_byte_t route1_q;
	pwmpm_byte_t preload_q;
	pwmpm_byte_t active_q;
	logic [3:0]  sys_cfg_q;
	logic [1:0]  ctrl_a_q;
	logic [1:0]  ctrl_b_q;
	logic        ug_a_q;
	logic        commutation_generate_bit_a_q;
	logic        ug_b_q;
	logic [3:0]  ctrl_sync;

	wire logic hit_r0  = ADDR_I == `PWMPM_ADDR_ROUTE0;
	wire logic hit_r1  = ADDR_I == `PWMPM_ADDR_ROUTE1;
	wire logic hit_ev  = ADDR_I == `PWMPM_ADDR_EVENT;
	wire logic hit_pre = ADDR_I == `PWMPM_ADDR_PRELOAD;
	wire logic hit_act = ADDR_I == `PWMPM_ADDR_ACTIVE;
	wire logic hit_ca  = ADDR_I == `PWMPM_ADDR_CTRL_A;
	wire logic hit_cb  = ADDR_I == `PWMPM_ADDR_CTRL_B;
	wire logic hit_cfg = ADDR_I == `PWMPM_ADDR_SYS_CFG;
	wire logic en_a    = sys_cfg_q[`PWMPM_CFG_A_EN];
	wire logic en_b    = sys_cfg_q[`PWMPM_CFG_B_EN];
	wire logic wr_ev   = WR_I && hit_ev;
	wire logic ug_a_d  = wr_ev && en_a && WDATA_I[`PWMPM_EV_A_UG];
	wire logic commutation_generate_bit_d  = wr_ev && en_a && WDATA_I[`PWMPM_EV_A_COMMUTATION_GENERATE_BIT];
	wire logic ug_b_d  = wr_ev && en_b && WDATA_I[`PWMPM_EV_B_UG];

	// Run and direction read back through the crossing, so late
	wire pwmpm_byte_t rd_mux =
		hit_r0  ? route0_q :
		hit_r1  ? route1_q :
		hit_pre ? preload_q :
		hit_act ? active_q :
		hit_ca  ? {6'h00, ctrl_sync[1:0]} :
		hit_cb  ? {6'h00, ctrl_sync[3:2]} :
		hit_cfg ? {4'h0, sys_cfg_q} : 8'h00;
	wire pwmpm_byte_t rdata_d = RD_I ? rd_mux : 8'h00;

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			route0_q  <= `PWMPM_RST_BYTE;
			route1_q  <= `PWMPM_RST_BYTE;
			preload_q <= `PWMPM_RST_BYTE;
			sys_cfg_q <= `PWMPM_RST_CFG;
			ctrl_a_q  <= `PWMPM_RST_CTRL;
			ctrl_b_q  <= `PWMPM_RST_CTRL;
		end else if (WR_I) begin
			if (hit_r0) route0_q <= WDATA_I;
			if (hit_r1) route1_q <= WDATA_I;
			if (hit_pre) preload_q <= WDATA_I;
			if (hit_cfg) sys_cfg_q <= WDATA_I[3:0];
			if (hit_ca) ctrl_a_q <= WDATA_I[1:0];
			if (hit_cb) ctrl_b_q <= WDATA_I[1:0];
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			active_q <= `PWMPM_RST_BYTE;
			ug_a_q   <= 1'b0;
			commutation_generate_bit_a_q <= 1'b0;
			ug_b_q   <= 1'b0;
			RDATA_O  <= 8'h00;
		end else begin
			if (commutation_generate_bit_d) active_q <= preload_q;
			ug_a_q   <= ug_a_d;
			commutation_generate_bit_a_q <= commutation_generate_bit_d;
			ug_b_q   <= ug_b_d;
			RDATA_O  <= rdata_d;
		end
	end

	// ****************************************************************
	// Counter run and direction crossing
	// ****************************************************************
	wire logic [3:0] ctrl_raw = {ctrl_b_q, ctrl_a_q};

	for (genvar i = 0; i < 4; i++) begin : g_sync
		pwmpm_sync2 u_sync (
			.clk_sys_i (CLK_SYS_I),
			.rst_i     (RST_I),
			.d_i       (ctrl_raw[i]),
			.q_o       (ctrl_sync[i])
		);
	end

	// Unit control, disabled unit held in reset with clock gated
	assign TA_CLK_EN_O     = en_a;
	assign TA_CNT_RST_O    = !en_a;
	assign TB_CLK_EN_O     = en_b;
	assign TB_CNT_RST_O    = !en_b;
	assign TA_CLK_SEL_O    = sys_cfg_q[`PWMPM_CFG_A_CLK];
	assign TB_CLK_SEL_O    = sys_cfg_q[`PWMPM_CFG_B_CLK];
	assign TA_RUN_O        = en_a && ctrl_sync[`PWMPM_CTRL_RUN];
	assign TA_DIR_O        = ctrl_sync[`PWMPM_CTRL_DIR];
	assign TB_RUN_O        = en_b && ctrl_sync[2];
	assign TB_DIR_O        = ctrl_sync[3];
	assign TA_UPDATE_GEN_O = ug_a_q;
	assign TA_COMMUT_GEN_O = commutation_generate_bit_a_q;
	assign TA_COMMUT_CFG_O = active_q;
	assign TB_UPDATE_GEN_O = ug_b_q;

	// ****************************************************************
	// Pin routing
	// ****************************************************************
	// Channel pins are claimed only while their unit is enabled
	pwmpm_pin_vec_t sel_hot [`PWMPM_NSRC];
	pwmpm_pin_vec_t trig_hot;
	pwmpm_pin_vec_t brk_hot;
	wire logic [`PWMPM_NSRC-1:0] src_out = {TB_CH_OUT_I, TA_CHN_OUT_I,
		TA_CH_OUT_I};
	wire logic [`PWMPM_NSRC-1:0] src_drv = {~TB_CH_DIR_I, 3'h7,
		~TA_CH_DIR_I};
	logic [`PWMPM_NSRC-1:0] src_in;

	assign sel_hot[PWMPM_SRC_A_CH1] = en_a ? hot3(route0_q[1:0],
		`PWMPM_PIN_PB1, `PWMPM_PIN_PB7, `PWMPM_PIN_PC7) : '0;
	assign sel_hot[PWMPM_SRC_A_CH2] = en_a ? hot3(route0_q[3:2],
		`PWMPM_PIN_PB0, `PWMPM_PIN_PB6, `PWMPM_PIN_PC6) : '0;
	assign sel_hot[PWMPM_SRC_A_CH3] = en_a ? hot3(route0_q[5:4],
		`PWMPM_PIN_PD4, `PWMPM_PIN_PB2, `PWMPM_PIN_PC4) : '0;
	assign sel_hot[PWMPM_SRC_A_CH1N] = en_a ? hot2(
		route1_q[`PWMPM_R1_CH1N_SEL], `PWMPM_PIN_PD1, `PWMPM_PIN_PB5) : '0;
	assign sel_hot[PWMPM_SRC_A_CH2N] = en_a ? hot2(
		route1_q[`PWMPM_R1_CH2N_SEL], `PWMPM_PIN_PA4, `PWMPM_PIN_PD2) : '0;
	assign sel_hot[PWMPM_SRC_A_CH3N] = en_a ? hot2(
		route1_q[`PWMPM_R1_CH3N_SEL], `PWMPM_PIN_PA5, `PWMPM_PIN_PD3) : '0;
	assign sel_hot[PWMPM_SRC_B_CH1] = en_b ? hot2(
		route1_q[`PWMPM_R1_B_CH1_SEL], `PWMPM_PIN_PA3, `PWMPM_PIN_PD0) : '0;
	assign sel_hot[PWMPM_SRC_B_CH2] = en_b ? hot2(
		route1_q[`PWMPM_R1_B_CH2_SEL], `PWMPM_PIN_PD1, `PWMPM_PIN_PC2) : '0;
	assign trig_hot = route0_q[`PWMPM_R0_ETR_EN] ? hot2(
		route0_q[`PWMPM_R0_ETR_SEL], `PWMPM_PIN_PA3,
		`PWMPM_PIN_PD4) : '0;
	assign brk_hot = route1_q[`PWMPM_R1_BRK_EN] ? hot3(route1_q[6:5],
		`PWMPM_PIN_PA1, `PWMPM_PIN_PB0, `PWMPM_PIN_PC6) : '0;

	wire logic trig_d = |(trig_hot & PIN_IN_I);
	wire logic brk_d  = |(brk_hot & PIN_IN_I);
	logic [`PWMPM_NPIN-1:0] alt_en_d;
	logic [`PWMPM_NPIN-1:0] alt_oe_d;
	logic [`PWMPM_NPIN-1:0] alt_out_d;

	for (genvar p = 0; p < `PWMPM_NPIN; p++) begin : g_pin
		logic [`PWMPM_NSRC-1:0] claim;
		logic [`PWMPM_NSRC-1:0] first;
		for (genvar s = 0; s < `PWMPM_NSRC; s++) begin : g_src
			assign claim[s] = sel_hot[s][p];
		end
		// Lowest source index owns a pin that two selectors share
		assign first = claim & (~claim + `PWMPM_NSRC'(1));
		assign alt_en_d[p]  = |claim || trig_hot[p] || brk_hot[p];
		assign alt_oe_d[p]  = |(first & src_drv);
		assign alt_out_d[p] = |(first & src_out);
	end

	for (genvar s = 0; s < `PWMPM_NSRC; s++) begin : g_in
		assign src_in[s] = |(sel_hot[s] & PIN_IN_I);
	end

	// Registered pins add one cycle of latency to every edge
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			PIN_ALT_EN_O  <= '0;
			PIN_ALT_OE_O  <= '0;
			PIN_ALT_OUT_O <= '0;
			EXT_TRIG_O    <= 1'b0;
			BREAK_O       <= 1'b0;
			TA_CH_IN_O    <= 3'h0;
			TB_CH_IN_O    <= 2'h0;
		end else begin
			PIN_ALT_EN_O  <= alt_en_d;
			PIN_ALT_OE_O  <= alt_oe_d;
			PIN_ALT_OUT_O <= alt_out_d;
			EXT_TRIG_O    <= trig_d;
			BREAK_O       <= brk_d;
			TA_CH_IN_O    <= src_in[2:0];
			TB_CH_IN_O    <= src_in[7:6];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	trig_gate_a: assert property (
		!route0_q[`PWMPM_R0_ETR_EN] |=> !EXT_TRIG_O)
		else $error("trigger passed while disabled");
	trig_pick_a: assert property (
		route0_q[`PWMPM_R0_ETR_EN] && !route0_q[`PWMPM_R0_ETR_SEL]
		|=> EXT_TRIG_O == $past(PIN_IN_I[`PWMPM_PIN_PA3]))
		else $error("trigger not taken from PA3");
	ch3_route_a: assert property (
		en_a && route0_q[5:4] == 2'h1
		|=> PIN_ALT_EN_O[`PWMPM_PIN_PB2] &&
		PIN_ALT_OUT_O[`PWMPM_PIN_PB2] == $past(TA_CH_OUT_I[2]))
		else $error("channel 3 not on PB2");
	ch2_route_a: assert property (
		en_a && route0_q[3:2] == 2'h1
		|=> PIN_ALT_OUT_O[`PWMPM_PIN_PB6] == $past(TA_CH_OUT_I[1]) &&
		PIN_ALT_OE_O[`PWMPM_PIN_PB6] == !$past(TA_CH_DIR_I[1]))
		else $error("channel 2 not on PB6");
	ch1_route_a: assert property (
		en_a && route0_q[1:0] == 2'h2 |=> PIN_ALT_EN_O[`PWMPM_PIN_PC7] &&
		!PIN_ALT_EN_O[`PWMPM_PIN_PB1])
		else $error("channel 1 not on PC7");
	brk_gate_a: assert property (
		!route1_q[`PWMPM_R1_BRK_EN] |=> !BREAK_O)
		else $error("break passed while disabled");
	unit_off_a: assert property (
		WR_I && hit_cfg && !WDATA_I[`PWMPM_CFG_A_EN]
		|=> TA_CNT_RST_O && !TA_CLK_EN_O && !TA_RUN_O)
		else $error("disabled unit still clocked");
	clk_src_a: assert property (
		WR_I && hit_cfg |=> TB_CLK_SEL_O == $past(WDATA_I[1]))
		else $error("clock source not taken");
	commut_a: assert property (
		wr_ev && en_a && WDATA_I[`PWMPM_EV_A_COMMUTATION_GENERATE_BIT]
		|=> TA_COMMUT_GEN_O && TA_COMMUT_CFG_O == $past(preload_q))
		else $error("commutation did not transfer");
	sync_lag_a: assert property (
		WR_I && hit_ca ##1 !(WR_I && hit_ca) [*3]
		|-> TA_DIR_O == $past(WDATA_I[1], 3))
		else $error("direction crossing latency wrong");
	code3_idle_a: assert property (
		route0_q[1:0] == 2'h3 |=> !PIN_ALT_EN_O[`PWMPM_PIN_PB1] &&
		!PIN_ALT_EN_O[`PWMPM_PIN_PB7] && !PIN_ALT_EN_O[`PWMPM_PIN_PC7])
		else $error("code 3 claimed a pin");

	commut_c: cover property (TA_COMMUT_GEN_O);
	trig_pd4_c: cover property (EXT_TRIG_O && route0_q[6]);
	brk_pc6_c: cover property (BREAK_O && route1_q[6:5] == 2'h2);
	run_c: cover property (TA_RUN_O && TB_RUN_O);

endmodule : pwmpm_top

// ---- tb/pwmpm_pin_model.sv ----
// Port pin model seen from outside the pin mux
`timescale 1ns/1ps
`include "pwmpm_defs.svh"

module pwmpm_pin_model (
	// Mux drive side
	input  wire logic [`PWMPM_NPIN-1:0] oe_i,
	input  wire logic [`PWMPM_NPIN-1:0] out_i,
	// Outside levels
	input  wire logic [`PWMPM_NPIN-1:0] ext_i,
	output logic      [`PWMPM_NPIN-1:0] pin_o
);
	// Driven pin reads its own drive, released pin the outside level
	assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : pwmpm_pin_model

// ---- tb/pwm_pin_mux_and_clock_enable_tb.sv ----
// Self-checking bench for the PWM pin mux and unit control
`timescale 1ns/1ps
`include "pwmpm_defs.svh"
`define CHK(nm, exp, act) begin compares++; if ((act) !== (exp)) begin \
	$display("MISMATCH %s exp %h got %h", nm, exp, act); bad_count++; end end

module pwm_pin_mux_and_clock_enable_tb;
	import pwmpm_pkg::*;

	logic        clk_sys, rst, wr, rd;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata, cfg_act;
	logic [2:0]  ta_out, ta_chn, ta_dir, ta_in;
	logic [1:0]  tb_out, tb_dir, tb_in;
	logic        ext_trig, brk, ta_en, ta_rst, ta_sel, ta_run, ta_dir_o;
	logic        ta_ug, ta_com, tb_en, tb_rst, tb_sel, tb_run, tb_dir_o, tb_ug;
	pwmpm_pin_vec_t ext_lvl, pin_in, alt_en, alt_oe, alt_out;
	int          bad_count, compares;
	localparam int pin_tab [0:2][0:2] = '{
		'{`PWMPM_PIN_PB1, `PWMPM_PIN_PB7, `PWMPM_PIN_PC7},
		'{`PWMPM_PIN_PB0, `PWMPM_PIN_PB6, `PWMPM_PIN_PC6},
		'{`PWMPM_PIN_PD4, `PWMPM_PIN_PB2, `PWMPM_PIN_PC4}};
	localparam int brk_tab [0:2] = '{`PWMPM_PIN_PA1, `PWMPM_PIN_PB0,
		`PWMPM_PIN_PC6};

	pwmpm_top dut_u (.CLK_SYS_I(clk_sys), .RST_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.TA_CH_OUT_I(ta_out), .TA_CHN_OUT_I(ta_chn), .TA_CH_DIR_I(ta_dir),
		.TB_CH_OUT_I(tb_out), .TB_CH_DIR_I(tb_dir), .TA_CH_IN_O(ta_in),
		.TB_CH_IN_O(tb_in), .EXT_TRIG_O(ext_trig), .BREAK_O(brk),
		.TA_CLK_EN_O(ta_en), .TA_CNT_RST_O(ta_rst), .TA_CLK_SEL_O(ta_sel),
		.TA_RUN_O(ta_run), .TA_DIR_O(ta_dir_o), .TA_UPDATE_GEN_O(ta_ug),
		.TA_COMMUT_GEN_O(ta_com), .TA_COMMUT_CFG_O(cfg_act),
		.TB_CLK_EN_O(tb_en), .TB_CNT_RST_O(tb_rst), .TB_CLK_SEL_O(tb_sel),
		.TB_RUN_O(tb_run), .TB_DIR_O(tb_dir_o), .TB_UPDATE_GEN_O(tb_ug),
		.PIN_IN_I(pin_in), .PIN_ALT_EN_O(alt_en), .PIN_ALT_OE_O(alt_oe),
		.PIN_ALT_OUT_O(alt_out));

	pwmpm_pin_model pins_u (.oe_i(alt_oe), .out_i(alt_out), .ext_i(ext_lvl),
		.pin_o(pin_in));

	always #50 clk_sys = ~clk_sys;

	// ****************************************************************
	// Bus and helper tasks
	// ****************************************************************
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e,
		input string nm);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		`CHK(nm, e, rdata)
	endtask : rd_chk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_cyc

	task automatic end_sim;
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		`CHK("cnt_rst_a", 1'b1, ta_rst)
		`CHK("cnt_rst_b", 1'b1, tb_rst)
		rd_chk(`PWMPM_ADDR_ROUTE0, 8'h00, "route0");
		rd_chk(`PWMPM_ADDR_ROUTE1, 8'h00, "route1");
		rd_chk(`PWMPM_ADDR_SYS_CFG, 8'h00, "sys_cfg");
		wr_reg(16'h2050, 8'hFF);
		rd_chk(16'h2050, 8'h00, "unmapped");
	endtask : t_reset

	task automatic t_unit;
		wr_reg(`PWMPM_ADDR_SYS_CFG, 8'hFF);
		`CHK("en_a", 1'b1, ta_en)
		`CHK("rst_b", 1'b0, tb_rst)
		`CHK("sel_a", 1'b1, ta_sel)
		rd_chk(`PWMPM_ADDR_SYS_CFG, 8'h0F, "cfg_rb");
		wr_reg(`PWMPM_ADDR_SYS_CFG, 8'h06);
		`CHK("sel_a0", 1'b0, ta_sel)
		`CHK("sel_b1", 1'b1, tb_sel)
		`CHK("rst_b1", 1'b1, tb_rst)
		`CHK("en_b0", 1'b0, tb_en)
	endtask : t_unit

	task automatic t_chan;
		logic [7:0] r;
		int p;
		wr_reg(`PWMPM_ADDR_SYS_CFG, 8'h04);
		for (int ch = 0; ch < 3; ch++) begin
			for (int code = 0; code < 4; code++) begin
				r = 8'h3F;
				r[2*ch +: 2] = code[1:0];
				@(posedge clk_sys);
				ta_out <= 3'b111;
				ta_dir <= 3'b000;
				ext_lvl <= '1;
				wr_reg(`PWMPM_ADDR_ROUTE0, r);
				wait_cyc(2);
				if (code < 3) begin
					p = pin_tab[ch][code];
					`CHK("ch_oe", 1'b1, alt_oe[p])
					`CHK("ch_out", 1'b1, alt_out[p])
					@(posedge clk_sys);
					ta_dir <= 3'b001 << ch;
					ta_out <= 3'b000;
					wait_cyc(2);
					`CHK("ch_in", 1'b1, ta_in[ch])
					`CHK("ch_oe_in", 1'b0, alt_oe[p])
				end else begin
					`CHK("c3_pins", 1'b0, alt_en[pin_tab[ch][0]] |
						alt_en[pin_tab[ch][1]] | alt_en[pin_tab[ch][2]])
					`CHK("c3_in", 1'b0, ta_in[ch])
				end
			end
		end
		wr_reg(`PWMPM_ADDR_ROUTE0, 8'h00);
		wr_reg(`PWMPM_ADDR_SYS_CFG, 8'h00);
		wait_cyc(2);
		`CHK("off_pin", 1'b0, alt_en[`PWMPM_PIN_PB1])
	endtask : t_chan

	task automatic t_trig;
		@(posedge clk_sys);
		ext_lvl <= pwmpm_pin_vec_t'(1) << `PWMPM_PIN_PA3;
		wr_reg(`PWMPM_ADDR_ROUTE0, 8'h3F);
		wait_cyc(2);
		`CHK("trig_off", 1'b0, ext_trig)
		wr_reg(`PWMPM_ADDR_ROUTE0, 8'hBF);
		wait_cyc(2);
		`CHK("trig_pa3", 1'b1, ext_trig)
		`CHK("trig_en", 1'b1, alt_en[`PWMPM_PIN_PA3])
		wr_reg(`PWMPM_ADDR_ROUTE0, 8'hFF);
		wait_cyc(2);
		`CHK("trig_pd4", 1'b0, ext_trig)
		@(posedge clk_sys);
		ext_lvl <= pwmpm_pin_vec_t'(1) << `PWMPM_PIN_PD4;
		wait_cyc(2);
		`CHK("trig_pd4_hi", 1'b1, ext_trig)
	endtask : t_trig

	task automatic t_brk;
		for (int code = 0; code < 4; code++) begin
			@(posedge clk_sys);
			ext_lvl <= (code < 3) ? pwmpm_pin_vec_t'(1) << brk_tab[code] : '1;
			wr_reg(`PWMPM_ADDR_ROUTE1, 8'h80 | 8'(code << 5));
			wait_cyc(2);
			`CHK("brk", code < 3, brk)
		end
		@(posedge clk_sys);
		ext_lvl <= '1;
		wr_reg(`PWMPM_ADDR_ROUTE1, 8'h00);
		wait_cyc(2);
		`CHK("brk_off", 1'b0, brk)
	endtask : t_brk

	task automatic t_cross;
		// Timer internals live elsewhere: no dead time, capture, prescaler
		// or counter writes are made, run is set last
		wr_reg(`PWMPM_ADDR_SYS_CFG, 8'h0C);
		wr_reg(`PWMPM_ADDR_CTRL_A, 8'h03);
		wait_cyc(1);
		`CHK("run_early", 1'b0, ta_run)
		wait_cyc(1);
		`CHK("run_a", 1'b1, ta_run)
		`CHK("dir_a", 1'b1, ta_dir_o)
		rd_chk(`PWMPM_ADDR_CTRL_A, 8'h03, "ctrl_a");
		wr_reg(`PWMPM_ADDR_CTRL_B, 8'h03);
		wait_cyc(1);
		`CHK("run_b_early", 1'b0, tb_run)
		wait_cyc(1);
		`CHK("dir_b", 1'b1, tb_dir_o)
		`CHK("run_b", 1'b1, tb_run)
		wr_reg(`PWMPM_ADDR_SYS_CFG, 8'h08);
		wait_cyc(1);
		`CHK("run_gate", 1'b0, ta_run)
		`CHK("run_b_kept", 1'b1, tb_run)
	endtask : t_cross

	task automatic t_event;
		wr_reg(`PWMPM_ADDR_SYS_CFG, 8'h04);
		wr_reg(`PWMPM_ADDR_PRELOAD, 8'hA5);
		wr_reg(`PWMPM_ADDR_ACTIVE, 8'h3C);
		rd_chk(`PWMPM_ADDR_ACTIVE, 8'h00, "act_ro");
		wr_reg(`PWMPM_ADDR_EVENT, 8'h02);
		`CHK("com_p", 1'b1, ta_com)
		`CHK("com_cfg", 8'hA5, cfg_act)
		wait_cyc(1);
		`CHK("com_end", 1'b0, ta_com)
		rd_chk(`PWMPM_ADDR_ACTIVE, 8'hA5, "act");
		wr_reg(`PWMPM_ADDR_EVENT, 8'h05);
		`CHK("ug_a", 1'b1, ta_ug)
		`CHK("ug_b", 1'b0, tb_ug)
		rd_chk(`PWMPM_ADDR_EVENT, 8'h00, "ev_rd");
	endtask : t_event

	// Shared pin PD1: timer A ch1n wins, timer B ch2 takes it once A is off
	task automatic t_comp;
		wr_reg(`PWMPM_ADDR_SYS_CFG, 8'h0C);
		wr_reg(`PWMPM_ADDR_ROUTE0, 8'h3F);
		@(posedge clk_sys);
		ta_chn <= 3'b101;
		tb_out <= 2'b01;
		tb_dir <= 2'b00;
		ext_lvl <= '0;
		wr_reg(`PWMPM_ADDR_ROUTE1, 8'h00);
		wait_cyc(2);
		`CHK("pd1_a", 2'b11, ({alt_oe[`PWMPM_PIN_PD1], alt_out[`PWMPM_PIN_PD1]}))
		`CHK("pa3_b", 2'b11, ({alt_oe[`PWMPM_PIN_PA3], alt_out[`PWMPM_PIN_PA3]}))
		`CHK("tb_in", 2'b11, tb_in)
		wr_reg(`PWMPM_ADDR_EVENT, 8'h04);
		`CHK("ug_b_on", 1'b1, tb_ug)
		wr_reg(`PWMPM_ADDR_SYS_CFG, 8'h08);
		wait_cyc(2);
		`CHK("pd1_b", 2'b10, ({alt_oe[`PWMPM_PIN_PD1], alt_out[`PWMPM_PIN_PD1]}))
		`CHK("pa4_off", 1'b0, alt_en[`PWMPM_PIN_PA4])
		@(posedge clk_sys);
		tb_dir <= 2'b01;
		tb_out <= 2'b00;
		ext_lvl <= pwmpm_pin_vec_t'(1) << `PWMPM_PIN_PA3;
		wait_cyc(2);
		`CHK("pa3_in", 2'b01, ({alt_oe[`PWMPM_PIN_PA3], tb_in[0]}))
	endtask : t_comp

	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		ta_out = '0;
		ta_chn = 3'b101;
		ta_dir = '0;
		tb_out = 2'b11;
		tb_dir = '0;
		ext_lvl = '0;
		bad_count = 0;
		compares = 0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		t_reset();
		t_unit();
		t_chan();
		t_trig();
		t_brk();
		t_cross();
		t_event();
		t_comp();
		end_sim();
	end

	// Whole run is well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		end_sim();
	end
endmodule : pwm_pin_mux_and_clock_enable_tb
